// >>> rtl/lmr_alu.sv
`timescale 1ns/1ps
module lmr_alu
   import lmr_pkg::*;
(
   // Operation and operands.
   input wire op_t op,
   input wire logic [DATA_W-1:0] acc,
   input wire logic [DATA_W-1:0] reg_value,
   input wire logic [DATA_W-1:0] literal_operand,
   input wire logic spill_in,
   // Result.
   output alu_res_t res
);

   // Pure combinational result; flags are chosen by the caller.
   always_comb
   begin
      res.value = acc;
      res.spill = spill_in;
      unique case (op)
         OP_OR_LITERAL_TO_ACC: res.value = acc | literal_operand;
         OP_LOAD_LITERAL_TO_ACC: res.value = literal_operand;
         OP_OR_ACC_WITH_REG: res.value = acc | reg_value;
         OP_STORE_ACC_TO_REG: res.value = acc;
         OP_COPY_REG: res.value = reg_value;
         OP_ROTATE_LEFT_THRU_SPILL:
         begin
            res.value = {reg_value[DATA_W-2:0], spill_in};
            res.spill = reg_value[DATA_W-1];
         end
         default: res.value = acc;
      endcase
   end

endmodule // lmr_alu

// >>> rtl/lmr_exec.sv
`timescale 1ns/1ps
// Contract
// - OR literal into accumulator, update zero
// - Load literal into accumulator, flags kept
// - OR accumulator with register, update zero
// - Select 0 accumulator, 1 register target
// - Store accumulator into register, flags kept
// - Copy register to target, update zero
// - Rotate left through spill, spill only
// - Subroutine return pops stack, two cycles
module lmr_exec
   import lmr_pkg::*;
(
   // Clock and reset.
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // Instruction from the decoder, taken when valid and ready.
   input wire logic INSTR_VALID,
   input wire instr_t INSTR,
   output logic INSTR_READY,
   // Program counter and call side of the stack.
   input wire logic PC_ADVANCE,
   input wire logic PUSH_VALID,
   input wire logic [PC_W-1:0] PUSH_ADDR,
   output logic [PC_W-1:0] PC,
   // Architectural state.
   output logic [DATA_W-1:0] ACC,
   output logic NULL_RESULT_FLAG,
   output logic SPILL_BIT,
   output logic GLOBAL_IRQ_ENABLE,
   // File register write port: enable, address and data.
   output logic REG_WE,
   output logic [ADDR_W-1:0] REG_WADDR,
   output logic [DATA_W-1:0] REG_WDATA
);

   typedef enum logic {ST_RUN, ST_RET2} phase_t;

   // Whole module state in one packed struct.
   typedef struct packed {
      phase_t phase;
      logic ready;
      logic [DATA_W-1:0] acc;
      logic zero;
      logic spill;
      logic global_irq_enable;
      logic [PC_W-1:0] pc;
      logic [SP_W-1:0] sp;
      logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
      logic [REG_ADDR_MAX:0][DATA_W-1:0] regs;
      logic we;
      logic [ADDR_W-1:0] waddr;
      logic [DATA_W-1:0] wdata;
   } state_t;

   state_t st;
   state_t next_st;
   alu_res_t res;
   logic take;
   logic [SP_W-1:0] pop_sp;

   assign take = INSTR_VALID && (st.phase == ST_RUN);
   assign pop_sp = st.sp - 3'h1;

   lmr_alu u_alu (
      .op(INSTR.op),
      .acc(st.acc),
      .reg_value(st.regs[INSTR.register_operand]),
      .literal_operand(INSTR.literal_operand),
      .spill_in(st.spill),
      .res(res)
   );

   // Next state; a return holds the pipeline for its second cycle.
   always_comb
   begin
      next_st = st;
      next_st.we = 1'b0;
      if (st.phase == ST_RET2)
      begin
         next_st.phase = ST_RUN;
      end
      else
      begin
         if (PC_ADVANCE)
         begin
            next_st.pc = st.pc + 13'h0001;
         end
         if (PUSH_VALID)
         begin
            next_st.stack[st.sp] = PUSH_ADDR;
            next_st.sp = st.sp + 3'h1;
         end
      end
      if (take)
      begin
         unique case (INSTR.op)
            OP_OR_LITERAL_TO_ACC, OP_LOAD_LITERAL_TO_ACC:
               next_st.acc = res.value;
            OP_STORE_ACC_TO_REG:
            begin
               next_st.regs[INSTR.register_operand] = res.value;
               next_st.we = 1'b1;
               next_st.waddr = INSTR.register_operand;
               next_st.wdata = res.value;
            end
            OP_OR_ACC_WITH_REG, OP_COPY_REG, OP_ROTATE_LEFT_THRU_SPILL:
            begin
               if (INSTR.result_target_select == DEST_ACC)
               begin
                  next_st.acc = res.value;
               end
               else
               begin
                  next_st.regs[INSTR.register_operand] = res.value;
                  next_st.we = 1'b1;
                  next_st.waddr = INSTR.register_operand;
                  next_st.wdata = res.value;
               end
            end
            OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN:
            begin
               next_st.pc = st.stack[pop_sp];
               next_st.sp = pop_sp;
               next_st.phase = ST_RET2;
               if (INSTR.op == OP_INTERRUPT_RETURN)
               begin
                  next_st.global_irq_enable = 1'b1;
               end
            end
            default: next_st.acc = st.acc;
         endcase
         if (INSTR.op inside {OP_OR_LITERAL_TO_ACC, OP_OR_ACC_WITH_REG, OP_COPY_REG})
         begin
            next_st.zero = (res.value == 8'h00);
         end
         if (INSTR.op == OP_ROTATE_LEFT_THRU_SPILL)
         begin
            next_st.spill = res.spill;
         end
      end
      // Ready is kept in its own flop so the port needs no decode after the register.
      next_st.ready = (next_st.phase == ST_RUN);
   end

   // State register with synchronous reset; file registers are cleared as well.
   always_ff @(posedge SYS_CLK)
   begin
      if (!RESET_N)
      begin
         st <= next_st;
         st.phase <= ST_RUN;
         st.ready <= 1'b1;
         st.acc <= ACC_RESET;
         st.zero <= 1'b0;
         st.spill <= 1'b0;
         st.global_irq_enable <= 1'b0;
         st.pc <= PC_RESET;
         st.sp <= SP_RESET;
         st.we <= 1'b0;
         st.waddr <= '0;
         st.wdata <= '0;
         st.stack <= '0;
         st.regs <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs straight from the state flip-flops.
   assign INSTR_READY = st.ready;
   assign ACC = st.acc;
   assign NULL_RESULT_FLAG = st.zero;
   assign SPILL_BIT = st.spill;
   assign GLOBAL_IRQ_ENABLE = st.global_irq_enable;
   assign PC = st.pc;
   assign REG_WE = st.we;
   assign REG_WADDR = st.waddr;
   assign REG_WDATA = st.wdata;

   property p_or_lit;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      take && INSTR.op == OP_OR_LITERAL_TO_ACC
         |=> ACC == ($past(st.acc) | $past(INSTR.literal_operand))
         && NULL_RESULT_FLAG == (ACC == 8'h00);
   endproperty
   a_or_lit: assert property (p_or_lit) else $error("OR literal wrong");

   property p_load;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      take && INSTR.op == OP_LOAD_LITERAL_TO_ACC |=> ACC == $past(INSTR.literal_operand)
         && $stable(NULL_RESULT_FLAG) && $stable(SPILL_BIT);
   endproperty
   a_load: assert property (p_load) else $error("literal load wrong");

   property p_or_reg;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      take && INSTR.op == OP_OR_ACC_WITH_REG |=> NULL_RESULT_FLAG == ($past(res.value) == 8'h00);
   endproperty
   a_or_reg: assert property (p_or_reg) else $error("OR register zero wrong");

   property p_dest;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      take && INSTR.op inside {OP_OR_ACC_WITH_REG, OP_COPY_REG, OP_ROTATE_LEFT_THRU_SPILL}
         |=> REG_WE == $past(INSTR.result_target_select) && (REG_WE || ACC == $past(res.value));
   endproperty
   a_dest: assert property (p_dest) else $error("destination wrong");

   property p_store;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      take && INSTR.op == OP_STORE_ACC_TO_REG |=> REG_WE && REG_WDATA == $past(st.acc)
         && $stable(NULL_RESULT_FLAG);
   endproperty
   a_store: assert property (p_store) else $error("store wrong");

   property p_copy;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      take && INSTR.op == OP_COPY_REG |=>
         NULL_RESULT_FLAG == ($past(st.regs[INSTR.register_operand]) == 8'h00);
   endproperty
   a_copy: assert property (p_copy) else $error("copy zero wrong");

   property p_rot;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      take && INSTR.op == OP_ROTATE_LEFT_THRU_SPILL |=>
         SPILL_BIT == $past(st.regs[INSTR.register_operand][7]) && $stable(NULL_RESULT_FLAG);
   endproperty
   a_rot: assert property (p_rot) else $error("rotate wrong");

   property p_ret;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      take && INSTR.op == OP_SUBROUTINE_RETURN |=> !INSTR_READY ##1 INSTR_READY;
   endproperty
   a_ret: assert property (p_ret) else $error("return timing wrong");

   property p_iret;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      take && INSTR.op == OP_INTERRUPT_RETURN |=> GLOBAL_IRQ_ENABLE && !INSTR_READY
         && PC == $past(st.stack[pop_sp]);
   endproperty
   a_iret: assert property (p_iret) else $error("interrupt return wrong");

endmodule // lmr_exec

// >>> rtl/lmr_pkg.sv
package lmr_pkg;

   // Operation codes presented by the decoder front end.
   typedef enum logic [3:0] {
      OP_IDLE_INSTR,
      OP_OR_LITERAL_TO_ACC,
      OP_LOAD_LITERAL_TO_ACC,
      OP_OR_ACC_WITH_REG,
      OP_STORE_ACC_TO_REG,
      OP_COPY_REG,
      OP_ROTATE_LEFT_THRU_SPILL,
      OP_SUBROUTINE_RETURN,
      OP_INTERRUPT_RETURN
   } op_t;

   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int PC_W = 13;
   localparam int STACK_DEPTH = 8;
   localparam int SP_W = 3;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
   localparam logic [SP_W-1:0] SP_RESET = 3'h0;
   localparam logic [ADDR_W-1:0] REG_ADDR_MAX = 7'h7F;
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_REG = 1'b1;
   // Instruction cycles taken by a return.
   localparam int RETURN_CYCLES = 2;

   // One instruction as handed over by the decoder.
   typedef struct packed {
      op_t op;
      logic [DATA_W-1:0] literal_operand;
      logic [ADDR_W-1:0] register_operand;
      logic result_target_select;
   } instr_t;

   // Result of the arithmetic unit.
   typedef struct packed {
      logic [DATA_W-1:0] value;
      logic spill;
   } alu_res_t;

endpackage

// >>> tb/logic_move_rotate_exec_bench.sv
`timescale 1ns/1ps
module logic_move_rotate_exec_bench;
   import lmr_pkg::*;

   logic clk, rst_n, valid, ready, pc_adv, push_v, zf, spill, global_irq_enable, we;
   instr_t instr;
   logic [PC_W-1:0] push_a, pc;
   logic [DATA_W-1:0] acc, wdata;
   logic [ADDR_W-1:0] waddr;
   int error_cnt = 0;
   int n_checks = 0;

   lmr_exec u_dut (.SYS_CLK(clk), .RESET_N(rst_n), .INSTR_VALID(valid), .INSTR(instr),
      .INSTR_READY(ready), .PC_ADVANCE(pc_adv), .PUSH_VALID(push_v), .PUSH_ADDR(push_a),
      .PC(pc), .ACC(acc), .NULL_RESULT_FLAG(zf), .SPILL_BIT(spill),
      .GLOBAL_IRQ_ENABLE(global_irq_enable), .REG_WE(we), .REG_WADDR(waddr), .REG_WDATA(wdata));

   // The clock runs at 50 MHz.
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic final_report;
      $display("checks %0d, errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
      begin
         $display("Regression OK");
      end
      else
      begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   // Presents one instruction and returns just after the edge that takes it.
   task automatic issue(input op_t op, input logic [7:0] lit, input logic [6:0] adr,
      input logic sel);
      int n;
      n = 0;
      @(posedge clk);
      valid <= 1'b1;
      instr <= {op, lit, adr, sel};
      #1;
      while (ready !== 1'b1 && n < 4)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 4)
      begin
         chk("ready wait", 16'h1, 16'h0);
         final_report();
      end
      @(posedge clk);
      valid <= 1'b0;
      #1;
   endtask

   task automatic t_literal;
      issue(OP_LOAD_LITERAL_TO_ACC, 8'hFF, 7'h00, 1'b0);
      chk("acc", 16'hFF, acc);
      chk("zero", 16'h0, zf);
      issue(OP_OR_LITERAL_TO_ACC, 8'h00, 7'h00, 1'b0);
      chk("acc", 16'hFF, acc);
      issue(OP_LOAD_LITERAL_TO_ACC, 8'h00, 7'h00, 1'b0);
      issue(OP_OR_LITERAL_TO_ACC, 8'h00, 7'h00, 1'b0);
      chk("zero", 16'h1, zf);
      issue(OP_LOAD_LITERAL_TO_ACC, 8'h5A, 7'h00, 1'b0);
      chk("zero", 16'h1, zf);
   endtask

   task automatic t_store_copy;
      issue(OP_STORE_ACC_TO_REG, 8'h00, 7'h7F, 1'b0);
      chk("we", 16'h1, we);
      chk("waddr", 16'h7F, waddr);
      chk("wdata", 16'h5A, wdata);
      chk("zero", 16'h1, zf);
      issue(OP_COPY_REG, 8'h00, 7'h03, 1'b0);
      chk("acc", 16'h00, acc);
      chk("we", 16'h0, we);
      issue(OP_COPY_REG, 8'h00, 7'h7F, 1'b1);
      chk("wdata", 16'h5A, wdata);
      chk("zero", 16'h0, zf);
      chk("acc", 16'h00, acc);
   endtask

   task automatic t_or_reg;
      issue(OP_LOAD_LITERAL_TO_ACC, 8'hA5, 7'h00, 1'b0);
      issue(OP_OR_ACC_WITH_REG, 8'h00, 7'h7F, 1'b1);
      chk("wdata", 16'hFF, wdata);
      chk("acc", 16'hA5, acc);
      issue(OP_LOAD_LITERAL_TO_ACC, 8'h00, 7'h00, 1'b0);
      issue(OP_OR_ACC_WITH_REG, 8'h00, 7'h03, 1'b0);
      chk("we", 16'h0, we);
      chk("zero", 16'h1, zf);
   endtask

   task automatic t_rotate;
      issue(OP_LOAD_LITERAL_TO_ACC, 8'h81, 7'h00, 1'b0);
      issue(OP_STORE_ACC_TO_REG, 8'h00, 7'h10, 1'b0);
      issue(OP_ROTATE_LEFT_THRU_SPILL, 8'h00, 7'h10, 1'b0);
      chk("acc", 16'h02, acc);
      chk("spill", 16'h1, spill);
      chk("zero", 16'h1, zf);
      issue(OP_ROTATE_LEFT_THRU_SPILL, 8'h00, 7'h10, 1'b1);
      chk("wdata", 16'h03, wdata);
      issue(OP_ROTATE_LEFT_THRU_SPILL, 8'h00, 7'h10, 1'b0);
      chk("acc", 16'h07, acc);
      chk("spill", 16'h0, spill);
   endtask

   // A return must pop the pushed address and stall the next instruction one cycle.
   task automatic t_return(input op_t op, input logic [PC_W-1:0] a);
      @(posedge clk);
      push_v <= 1'b1;
      push_a <= a;
      @(posedge clk);
      push_v <= 1'b0;
      issue(op, 8'h00, 7'h00, 1'b0);
      chk("pc", 16'(a), 16'(pc));
      chk("ready", 16'h0, ready);
      chk("irq enable", 16'h1, global_irq_enable);
      chk("acc", 16'h07, acc);
      chk("zero", 16'h1, zf);
      chk("spill", 16'h0, spill);
      @(posedge clk);
      #1;
      chk("ready", 16'h1, ready);
   endtask

   // Reset is held for three cycles, then each scenario runs in turn.
   initial
   begin
      rst_n = 1'b0;
      valid = 1'b0;
      instr = '0;
      pc_adv = 1'b0;
      push_v = 1'b0;
      push_a = '0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("acc", 16'h00, acc);
      chk("irq enable", 16'h0, global_irq_enable);
      chk("ready", 16'h1, ready);
      t_literal();
      t_store_copy();
      t_or_reg();
      t_rotate();
      issue(OP_IDLE_INSTR, 8'hFF, 7'h10, 1'b1);
      chk("we", 16'h0, we);
      @(posedge clk);
      pc_adv <= 1'b1;
      repeat (3) @(posedge clk);
      pc_adv <= 1'b0;
      #1;
      chk("pc", 16'h3, 16'(pc));
      t_return(OP_INTERRUPT_RETURN, 13'h1234);
      t_return(OP_SUBROUTINE_RETURN, 13'h0ABC);
      final_report();
   end
endmodule // logic_move_rotate_exec_bench
